// >>> hdl/ttc_pkg.sv
// Purpose: Constants for the timer three control block
// Assumes: 8-bit special function register port, system clock domain
// Notes: Bit positions follow the control register layout
package ttc_pkg;
	localparam logic [7:0] ttc_ctrl_addr = 8'h91;
	localparam logic [7:0] ttc_rll_addr = 8'h92;
	localparam logic [7:0] ttc_rlh_addr = 8'h93;
	localparam logic [7:0] ttc_cnl_addr = 8'h94;
	localparam logic [7:0] ttc_cnh_addr = 8'h95;
	localparam int ttc_hflag_bit = 7;
	localparam int ttc_lflag_bit = 6;
	localparam int ttc_lien_bit = 5;
	localparam int ttc_capen_bit = 4;
	localparam int ttc_split_bit = 3;
	localparam int ttc_run_bit = 2;
	localparam int ttc_xclk_bit = 0;
	localparam logic [7:0] ttc_byte_reset = 8'h00;
	localparam logic [7:0] ttc_byte_max = 8'hff;
	localparam int ttc_sys_div = 12;
	localparam logic [3:0] ttc_div_last = 4'(ttc_sys_div - 1);
	localparam int ttc_ext_div = 8;
	localparam logic [2:0] ttc_ext_last = 3'(ttc_ext_div - 1);
endpackage : ttc_pkg

// >>> hdl/ttc_timer_three_control.sv
// Purpose: Timer three control register, counters, reload and capture logic
// Assumes: External oscillator is asynchronous and much slower than clock
// Notes: Register port is a simple SFR style address/strobe interface
`timescale 1ns/1ps
module ttc_timer_three_control (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic ext_osc,
	input wire logic high_byte_clock_select,
	input wire logic low_byte_clock_select,
	input wire logic timer_int_enable,
	output logic irq
);
	logic [7:0] count_low_byte_r;
	logic [7:0] count_high_byte_r;
	logic [7:0] reload_low_byte_r;
	logic [7:0] reload_high_byte_r;
	logic high_byte_overflow_flag_r;
	logic low_byte_overflow_flag_r;
	logic low_byte_interrupt_enable_r;
	logic capture_mode_enable_r;
	logic split_mode_select_r;
	logic run_control_r;
	logic external_clock_select_r;
	logic [2:0] osc_sync_r;
	logic osc_level_r;
	logic [2:0] osc_div_r;
	logic ext_tick_r;
	logic cap_tick_r;
	logic [3:0] sys_div_r;
	logic sys_tick;
	logic sel_tick;
	logic low_tick;
	logic high_tick;
	logic low_wrap;
	logic high_wrap;
	logic high_set;
	logic low_set;
	logic wr_ctrl;
	logic [7:0] low_nxt;
	logic [7:0] high_nxt;

	assign wr_ctrl = sfr_wr && (sfr_addr == ttc_pkg::ttc_ctrl_addr);

	// Three-stage synchroniser; a level counts once stages two and three agree
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			osc_sync_r <= 3'h0;
			osc_level_r <= 1'b0;
		end
		else
		begin
			osc_sync_r <= {osc_sync_r[1:0], ext_osc};
			if (osc_sync_r[1] == osc_sync_r[2])
				osc_level_r <= osc_sync_r[2];
		end
	end

	// Divide by eight, emit one-cycle enables
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			osc_div_r <= 3'h0;
			ext_tick_r <= 1'b0;
			cap_tick_r <= 1'b0;
		end
		else
		begin
			ext_tick_r <= 1'b0;
			cap_tick_r <= 1'b0;
			if (osc_level_r != osc_sync_r[2] && osc_sync_r[1] == osc_sync_r[2] && osc_sync_r[2])
			begin
				osc_div_r <= osc_div_r + 3'h1;
				if (osc_div_r == ttc_pkg::ttc_ext_last)
					cap_tick_r <= 1'b1;
				// Rising edge of divided clock steps the counter, half way through the count of eight
				if (osc_div_r == (ttc_pkg::ttc_ext_last >> 1))
					ext_tick_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			sys_div_r <= 4'h0;
		else if (sys_div_r == ttc_pkg::ttc_div_last)
			sys_div_r <= 4'h0;
		else
			sys_div_r <= sys_div_r + 4'h1;
	end
	assign sys_tick = (sys_div_r == ttc_pkg::ttc_div_last);

	assign sel_tick = external_clock_select_r ? ext_tick_r : sys_tick;

	// Per-byte override; both bytes share one source in 16-bit mode
	always_comb
	begin
		low_tick = low_byte_clock_select ? 1'b1 : sel_tick;
		high_tick = high_byte_clock_select ? 1'b1 : sel_tick;
		// Capture mode: the low byte never counts the external source
		if (capture_mode_enable_r)
			low_tick = low_byte_clock_select ? 1'b1 : sys_tick;
		if (split_mode_select_r)
		begin
			// Low byte free-running in split mode
			high_tick = high_tick && run_control_r;
		end
		else
		begin
			low_tick = low_tick && run_control_r;
			high_tick = low_tick;
		end
	end

	// Carry between bytes only in 16-bit mode
	assign low_wrap = low_tick && (count_low_byte_r == ttc_pkg::ttc_byte_max);
	assign high_wrap = split_mode_select_r ? (high_tick && (count_high_byte_r == ttc_pkg::ttc_byte_max))
		: (low_wrap && (count_high_byte_r == ttc_pkg::ttc_byte_max));

	always_comb
	begin
		low_nxt = count_low_byte_r;
		high_nxt = count_high_byte_r;
		if (split_mode_select_r)
		begin
			if (low_tick)
				low_nxt = low_wrap ? reload_low_byte_r : count_low_byte_r + 8'h01;
			if (high_tick)
				high_nxt = high_wrap ? reload_high_byte_r : count_high_byte_r + 8'h01;
		end
		else if (low_tick)
		begin
			if (high_wrap)
			begin
				low_nxt = reload_low_byte_r;
				high_nxt = reload_high_byte_r;
			end
			else
			begin
				low_nxt = count_low_byte_r + 8'h01;
				if (low_wrap)
					high_nxt = count_high_byte_r + 8'h01;
			end
		end
	end

	// Software writes to the count take effect over hardware stepping
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			count_low_byte_r <= ttc_pkg::ttc_byte_reset;
			count_high_byte_r <= ttc_pkg::ttc_byte_reset;
		end
		else
		begin
			count_low_byte_r <= (sfr_wr && sfr_addr == ttc_pkg::ttc_cnl_addr) ? sfr_wdata : low_nxt;
			count_high_byte_r <= (sfr_wr && sfr_addr == ttc_pkg::ttc_cnh_addr) ? sfr_wdata : high_nxt;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			reload_low_byte_r <= ttc_pkg::ttc_byte_reset;
			reload_high_byte_r <= ttc_pkg::ttc_byte_reset;
		end
		else if (capture_mode_enable_r && cap_tick_r)
		begin
			reload_low_byte_r <= count_low_byte_r;
			reload_high_byte_r <= count_high_byte_r;
		end
		else
		begin
			if (sfr_wr && sfr_addr == ttc_pkg::ttc_rll_addr)
				reload_low_byte_r <= sfr_wdata;
			if (sfr_wr && sfr_addr == ttc_pkg::ttc_rlh_addr)
				reload_high_byte_r <= sfr_wdata;
		end
	end

	// High flag source; in capture mode only the capture sets it
	assign high_set = (high_wrap && !capture_mode_enable_r) || (capture_mode_enable_r && cap_tick_r);
	assign low_set = low_wrap;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			high_byte_overflow_flag_r <= 1'b0;
			low_byte_overflow_flag_r <= 1'b0;
			low_byte_interrupt_enable_r <= 1'b0;
			capture_mode_enable_r <= 1'b0;
			split_mode_select_r <= 1'b0;
			run_control_r <= 1'b0;
			external_clock_select_r <= 1'b0;
		end
		else
		begin
			// Set beats write; only software clears
			if (high_set)
				high_byte_overflow_flag_r <= 1'b1;
			else if (wr_ctrl)
				high_byte_overflow_flag_r <= sfr_wdata[ttc_pkg::ttc_hflag_bit];
			if (low_set)
				low_byte_overflow_flag_r <= 1'b1;
			else if (wr_ctrl)
				low_byte_overflow_flag_r <= sfr_wdata[ttc_pkg::ttc_lflag_bit];
			if (wr_ctrl)
			begin
				low_byte_interrupt_enable_r <= sfr_wdata[ttc_pkg::ttc_lien_bit];
				capture_mode_enable_r <= sfr_wdata[ttc_pkg::ttc_capen_bit];
				split_mode_select_r <= sfr_wdata[ttc_pkg::ttc_split_bit];
				run_control_r <= sfr_wdata[ttc_pkg::ttc_run_bit];
				external_clock_select_r <= sfr_wdata[ttc_pkg::ttc_xclk_bit];
			end
		end
	end

	// Interrupt request is a level held by the flags
	assign irq = timer_int_enable && (high_byte_overflow_flag_r
		|| (low_byte_interrupt_enable_r && low_byte_overflow_flag_r));

	// Bit 1 and unmapped addresses read zero
	always_comb
	begin
		sfr_rdata = 8'h00;
		case (sfr_addr)
			ttc_pkg::ttc_ctrl_addr: sfr_rdata = {high_byte_overflow_flag_r, low_byte_overflow_flag_r,
				low_byte_interrupt_enable_r, capture_mode_enable_r, split_mode_select_r, run_control_r,
				1'b0, external_clock_select_r};
			ttc_pkg::ttc_rll_addr: sfr_rdata = reload_low_byte_r;
			ttc_pkg::ttc_rlh_addr: sfr_rdata = reload_high_byte_r;
			ttc_pkg::ttc_cnl_addr: sfr_rdata = count_low_byte_r;
			ttc_pkg::ttc_cnh_addr: sfr_rdata = count_high_byte_r;
			default: sfr_rdata = 8'h00;
		endcase
	end
endmodule : ttc_timer_three_control

// >>> testbench/ttc_sva.sv
// Purpose: Port checks for the timer three control block
// Assumes: Control bits 5:0 change only by software writes
// Notes: Shadows the control bits so counts can be judged
`timescale 1ns/1ps
module ttc_sva (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic low_byte_clock_select,
	input wire logic timer_int_enable,
	input wire logic irq
);
	logic [5:0] sh_r;
	logic ctl;
	logic cnl;
	assign ctl = sfr_addr == ttc_pkg::ttc_ctrl_addr;
	assign cnl = sfr_addr == ttc_pkg::ttc_cnl_addr;
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			sh_r <= 6'h00;
		else if (sfr_wr && ctl)
			sh_r <= sfr_wdata[5:0];
	end
	default clocking dcb @(posedge clock);
	endclocking
	default disable iff (rst);
	sequence s_ctl_wr;
		sfr_wr && ctl ##1 ctl;
	endsequence
	// Low count watched over one quiet edge
	sequence s_cnl_quiet;
		cnl && !sfr_wr ##1 cnl;
	endsequence
	a_unused_bit_low: assert property (ctl |-> !sfr_rdata[1])
		else $error("unused control bit reads one");
	a_ctrl_wr_back: assert property (s_ctl_wr |-> sfr_rdata[5:0] == ($past(sfr_wdata[5:0]) & 6'h3d))
		else $error("control write not read back");
	a_irq_high: assert property (ctl && timer_int_enable && sfr_rdata[7] |-> irq)
		else $error("high flag without request");
	a_irq_low: assert property (ctl && timer_int_enable && sfr_rdata[6] && sfr_rdata[5] |-> irq)
		else $error("low flag without request");
	a_irq_quiet: assert property (ctl && !(timer_int_enable && (sfr_rdata[7] || sfr_rdata[6] && sfr_rdata[5])) |-> !irq)
		else $error("request without cause");
	a_flag_sticky: assert property (ctl && !sfr_wr ##1 ctl |-> (sfr_rdata[7:6] & $past(sfr_rdata[7:6])) == $past(sfr_rdata[7:6]))
		else $error("flag cleared by hardware");
	a_hold_stopped: assert property (!sh_r[2] && !sh_r[3] ##0 s_cnl_quiet |-> $stable(sfr_rdata))
		else $error("count moved while stopped");
	a_low_free: assert property (sh_r[3] && low_byte_clock_select ##0 s_cnl_quiet
		|-> sfr_rdata == $past(sfr_rdata) + 8'h01 || $past(sfr_rdata) == 8'hff)
		else $error("split low byte not stepping");
endmodule : ttc_sva
bind ttc_timer_three_control ttc_sva i_sva (
	.clock(clock),
	.rst(rst),
	.sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr),
	.sfr_wdata(sfr_wdata),
	.sfr_rdata(sfr_rdata),
	.low_byte_clock_select(low_byte_clock_select),
	.timer_int_enable(timer_int_enable),
	.irq(irq)
);

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench for the timer three control block
// Assumes: Writes land on the rising edge after the drive
// Notes: Oscillator phase is unrelated to the clock
`timescale 1ns/1ps
module tb_top;
	localparam logic [7:0] ca = ttc_pkg::ttc_ctrl_addr;
	localparam logic [7:0] rl = ttc_pkg::ttc_rll_addr;
	localparam logic [7:0] cl = ttc_pkg::ttc_cnl_addr;
	logic clock = 0, rst = 1, sfr_wr = 0, ext_osc = 0, irq, xen = 0;
	logic high_byte_clock_select = 0, low_byte_clock_select = 0, timer_int_enable = 0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, v, w;
	logic [15:0] a, b;
	int mismatches = 0, n_tests = 0;
	ttc_timer_three_control i_dut (
		.clock(clock),
		.rst(rst),
		.sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata),
		.ext_osc(ext_osc),
		.high_byte_clock_select(high_byte_clock_select),
		.low_byte_clock_select(low_byte_clock_select),
		.timer_int_enable(timer_int_enable),
		.irq(irq)
	);
	always #2 clock = ~clock;
	// Oscillator stands still while disabled
	always #21.3 if (xen) ext_osc = ~ext_osc;
	function logic irq_exp(input logic [7:0] c, input logic en);
		return en & (c[7] | c[6] & c[5]);
	endfunction : irq_exp
	task chk(input logic [15:0] s, e);
		n_tests++;
		if (s !== e)
		begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [7:0] ad, d);
		@(negedge clock);
		sfr_addr = ad;
		sfr_wdata = d;
		sfr_wr = 1;
		@(negedge clock);
		sfr_wr = 0;
	endtask : wr
	task rd(input logic [7:0] ad, output logic [7:0] d);
		@(negedge clock);
		sfr_addr = ad;
		@(negedge clock);
		d = sfr_rdata;
	endtask : rd
	task r16(input logic [7:0] ad, output logic [15:0] d);
		rd(ad, d[7:0]);
		rd(ad + 8'h01, d[15:8]);
	endtask : r16
	task end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	initial
	begin
		#200000;
		mismatches++;
		end_sim();
	end
	initial
	begin
		void'($urandom(88019));
		repeat (8) @(posedge clock);
		@(negedge clock);
		rst = 0;
		for (int i = 8'h90; i < 8'h97; i++)
		begin
			rd(8'(i), v);
			chk(v, 8'h00);
		end
		$display("reset values done");
		for (int i = 0; i < 10; i++)
		begin
			w = i == 0 ? 8'hff : i == 1 ? 8'h02 : 8'($urandom);
			timer_int_enable = 1'($urandom);
			wr(ca, w);
			rd(ca, v);
			chk(v, w & 8'hfd);
			chk(irq, irq_exp(w, timer_int_enable));
		end
		wr(ca, 8'h00);
		$display("control access done");
		timer_int_enable = 1;
		high_byte_clock_select = 1;
		low_byte_clock_select = 1;
		a = {1'b0, 15'($urandom)};
		wr(rl, a[7:0]);
		wr(rl + 8'h01, a[15:8]);
		// Low wrap only; the clear lands with the hardware set
		wr(cl, 8'hfe);
		wr(cl + 8'h01, 8'h12);
		wr(ca, 8'h04);
		wr(ca, 8'h00);
		rd(ca, v);
		chk(v, 8'h40);
		r16(cl, b);
		chk(b, 16'h1300);
		wr(cl, 8'hff);
		wr(cl + 8'h01, 8'hff);
		wr(ca, 8'h04);
		wr(ca, 8'hc0);
		rd(ca, v);
		chk(v, 8'hc0);
		chk(irq, 1'b1);
		r16(cl, b);
		chk(b, a + 16'h0001);
		wr(ca, 8'h00);
		rd(ca, v);
		chk({v, 7'h00, irq}, 16'h0000);
		$display("sixteen bit done");
		wr(rl, 8'h80);
		wr(rl + 8'h01, 8'h5a);
		wr(cl, 8'hff);
		wr(cl + 8'h01, 8'h33);
		wr(ca, 8'h08);
		rd(cl, v);
		rd(cl + 8'h01, v);
		chk(v, 8'h33);
		rd(ca, v);
		chk({v, 7'h00, irq}, 16'h4800);
		wr(ca, 8'h68);
		chk(irq, 1'b1);
		wr(cl + 8'h01, 8'hff);
		wr(ca, 8'h0c);
		rd(ca, v);
		chk(v & 8'hbf, 8'h8c);
		wr(ca, 8'h00);
		$display("split mode done");
		high_byte_clock_select = 0;
		low_byte_clock_select = 0;
		wr(ca, 8'h04);
		rd(cl, v);
		repeat (118) @(negedge clock);
		rd(cl, w);
		chk(8'(w - v), 8'h0a);
		wr(ca, 8'h05);
		xen = 1;
		rd(cl, v);
		repeat (679) @(negedge clock);
		rd(cl, w);
		chk(8'(w - v) inside {[8'h07:8'h09]}, 1'b1);
		// Split mode: the high byte follows the external source too
		wr(ca, 8'h0d);
		rd(cl + 8'h01, v);
		repeat (679) @(negedge clock);
		rd(cl + 8'h01, w);
		chk(8'(w - v) inside {[8'h07:8'h09]}, 1'b1);
		$display("clock select done");
		wr(ca, 8'h00);
		wr(cl, 8'h00);
		wr(cl + 8'h01, 8'h00);
		low_byte_clock_select = 1;
		wr(ca, 8'h14);
		repeat (400) @(negedge clock);
		// Only a capture can have set the high flag here
		rd(ca, v);
		chk(v & 8'hbf, 8'h94);
		wr(ca, 8'h80);
		xen = 0;
		rd(ca, v);
		chk(v, 8'h80);
		r16(rl, a);
		r16(cl, b);
		chk((b - a) < 16'd350 && a != 16'h0000, 1'b1);
		$display("capture done");
		end_sim();
	end
endmodule : tb_top
